// ---- dv/hub_port_phy_config_regs_bench.sv ----
// Self-checking bench for the hub port PHY configuration registers
module hub_port_phy_config_regs_bench
    import hpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Design connections
    logic             clk;
    logic             rst;
    hpc_req_s         req;
    logic [7:0]       reg_rdata;
    logic             reg_ack;
    logic             remap_enable;
    hpc_pair_s [3:1]  xcvr_tx;
    hpc_pair_s [3:1]  xcvr_rx;
    logic [3:1]       plus_pin_i;
    logic [3:1]       minus_pin_i;
    logic [3:1]       plus_pin_o;
    logic [3:1]       minus_pin_o;
    logic [3:1]       pin_oe;
    logic [2:0]       port1_boost_code;
    logic [2:0]       port2_boost_code;
    logic [2:0]       port3_boost_code;
    hpc_pct_t [3:1]   boost_pct;
    logic [3:1]       swap;
    logic [1:0]       port1_logical;
    logic [1:0]       port2_logical;
    logic [1:0]       port_count;

    // Bench state
    int               errors;
    int               cmp_count;
    logic [7:0]       rd_val;
    logic [2:0]       cv;
    logic [3:0]       cv4;
    logic [1:0]       exp_l;
    logic [3:1]       ms;

    hpc_config_regs dut (
        .clk              (clk),
        .rst              (rst),
        .req              (req),
        .reg_rdata        (reg_rdata),
        .reg_ack          (reg_ack),
        .remap_enable     (remap_enable),
        .xcvr_tx          (xcvr_tx),
        .xcvr_rx          (xcvr_rx),
        .plus_pin_i       (plus_pin_i),
        .minus_pin_i      (minus_pin_i),
        .plus_pin_o       (plus_pin_o),
        .minus_pin_o      (minus_pin_o),
        .pin_oe           (pin_oe),
        .port1_boost_code (port1_boost_code),
        .port2_boost_code (port2_boost_code),
        .port3_boost_code (port3_boost_code),
        .boost_pct        (boost_pct),
        .swap             (swap),
        .port1_logical    (port1_logical),
        .port2_logical    (port2_logical),
        .port_count       (port_count)
    );

    // Clock, 10 ns period
    always #5 clk = ~clk;

    // Verdict and end of run
    task automatic summarize();
        if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize

    // One comparison, reported at once on mismatch
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    // One register access, ack checked and read data captured just after the taking edge
    task automatic access(input logic w, input logic r, input logic [7:0] a,
                          input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        #1;
        chk({7'h00, reg_ack}, 8'h01, "access ack");
        rd_val = reg_rdata;
    endtask : access

    // Write, then let the outputs settle one more cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        access(1'b1, 1'b0, a, d);
        @(posedge clk);
        #1;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
        access(1'b0, 1'b1, a, 8'h00);
        chk(rd_val, exp, msg);
    endtask : rd_chk

    // Expected signed percentage per boost code
    function automatic logic [5:0] pct_of(input logic [2:0] c);
        case (c)
            3'h1:    return 6'h3b;
            3'h2:    return 6'h0a;
            3'h3:    return 6'h05;
            3'h4:    return 6'h14;
            3'h5:    return 6'h0f;
            3'h6:    return 6'h19;
            default: return 6'h00;
        endcase
    endfunction : pct_of

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        summarize();
    end

    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        remap_enable = 1'b0;
        xcvr_tx = '0;
        plus_pin_i = '0;
        minus_pin_i = '0;
        errors = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_chk(HPC_OFS_BOOST3, 8'h00, "boost3 reset");
        rd_chk(HPC_OFS_BOOST21, 8'h00, "boost21 reset");
        rd_chk(HPC_OFS_SWAP, 8'h00, "swap reset");
        rd_chk(HPC_OFS_REMAP12, 8'h21, "remap reset");
        // Unmapped place and reserved bits
        wr(8'hf7, 8'hff);
        rd_chk(8'hf7, 8'h00, "unmapped read");
        wr(HPC_OFS_BOOST3, 8'hff);
        rd_chk(HPC_OFS_BOOST3, 8'h07, "boost3 reserved");
        wr(HPC_OFS_BOOST21, 8'hff);
        rd_chk(HPC_OFS_BOOST21, 8'h77, "boost21 reserved");
        wr(HPC_OFS_SWAP, 8'hff);
        rd_chk(HPC_OFS_SWAP, 8'h0e, "swap reserved");
        // Every boost code on every port, port 2 one code ahead
        for (int c = 0; c < 8; c++) begin
            cv = c[2:0];
            wr(HPC_OFS_BOOST3, {5'h00, cv});
            wr(HPC_OFS_BOOST21, {1'b0, cv + 3'h1, 1'b0, cv});
            chk({5'h00, port3_boost_code}, {5'h00, cv}, "port3 code");
            chk({5'h00, port1_boost_code}, {5'h00, cv}, "port1 code");
            chk({5'h00, port2_boost_code}, {5'h00, cv + 3'h1}, "port2 code");
            chk({2'h0, boost_pct[3]}, {2'h0, pct_of(cv)}, "port3 pct");
            chk({2'h0, boost_pct[1]}, {2'h0, pct_of(cv)}, "port1 pct");
            chk({2'h0, boost_pct[2]}, {2'h0, pct_of(cv + 3'h1)}, "port2 pct");
        end
        // Swap routing in both directions for all port combinations
        @(posedge clk);
        xcvr_tx <= {3{3'b101}};
        plus_pin_i <= 3'h7;
        minus_pin_i <= 3'h0;
        for (int m = 0; m < 8; m++) begin
            ms = m[2:0];
            wr(HPC_OFS_SWAP, {4'h0, ms, 1'b0});
            repeat (4) @(posedge clk);
            #1;
            chk({5'h00, swap}, {5'h00, ms}, "swap bits");
            chk({5'h00, plus_pin_o}, {5'h00, ~ms}, "plus pin drive");
            chk({5'h00, minus_pin_o}, {5'h00, ms}, "minus pin drive");
            chk({5'h00, pin_oe}, 8'h07, "pin enable");
            for (int k = 1; k < 4; k++) begin
                chk({5'h00, xcvr_rx[k]}, {5'h00, ~ms[k], ms[k], 1'b0}, "rx pair");
            end
        end
        // Output enable follows the transceiver when it stops driving
        @(posedge clk);
        xcvr_tx <= {3{3'b100}};
        repeat (2) @(posedge clk);
        #1;
        chk({5'h00, pin_oe}, 8'h00, "pin enable off");
        // Every remap code on both nibbles with remapping on
        @(posedge clk);
        remap_enable <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            cv4 = i[3:0];
            exp_l = (cv4 <= HPC_REMAP_LAST) ? cv4[1:0] : 2'h0;
            if (i < 16) begin
                wr(HPC_OFS_REMAP12, {cv4, 4'h1});
                chk({6'h00, port2_logical}, {6'h00, exp_l}, "port2 logical");
            end else begin
                wr(HPC_OFS_REMAP12, {4'h2, cv4});
                chk({6'h00, port1_logical}, {6'h00, exp_l}, "port1 logical");
            end
            chk({6'h00, port_count}, (exp_l == 2'h0) ? 8'h02 : 8'h03, "port count");
        end
        // Contiguous mapping with ports 1 and 2 exchanged
        wr(HPC_OFS_REMAP12, 8'h12);
        chk({6'h00, port1_logical}, 8'h02, "port1 exchanged logical");
        chk({6'h00, port2_logical}, 8'h01, "port2 exchanged logical");
        chk({6'h00, port_count}, 8'h03, "exchanged count");
        wr(HPC_OFS_REMAP12, 8'h00);
        chk({6'h00, port_count}, 8'h01, "both disabled count");
        // Remapping off restores physical numbering
        @(posedge clk);
        remap_enable <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({6'h00, port1_logical}, 8'h01, "port1 unmapped");
        chk({6'h00, port2_logical}, 8'h02, "port2 unmapped");
        chk({6'h00, port_count}, 8'h03, "count unmapped");
        // Second reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd_chk(HPC_OFS_REMAP12, 8'h21, "remap second reset");
        rd_chk(HPC_OFS_BOOST21, 8'h00, "boost21 second reset");
        summarize();
    end

endmodule : hub_port_phy_config_regs_bench

// ---- inc/hpc_pkg.sv ----
// Constants and carrier types for the hub port PHY configuration registers
// Overview of operation
// [R1] Port 3 boost code sits in bits 2:0 of its register: 000 nominal, 001 -5%, 010 +10%, 011 +5%, 100 +20%, 101 +15%.
// [R2] Port 2 boost code sits in bits 6:4 of the shared two-port boost register with the same decoding.
// [R3] Port 1 boost code sits in bits 2:0 of the shared register, which resets to zero (nominal drive on both ports).
// [R4] Code 110 selects the +25% setting and code 111 keeps nominal drive.
// [R5] A clear swap bit routes D+ to the plus pin and D- to the minus pin, a set bit exchanges them.
// [R6] Swap controls for ports 3, 2 and 1 sit at bits 3, 2 and 1; bit 0 and bits 7:4 are reserved.
// [R7] The upper remap nibble sets physical port 2: 0000 disabled, 0001 to 0011 logical port 1 to 3.
// [R8] A remap code of 0100 or above acts as 0000 and disables that physical port.
// [R9] The lower remap nibble sets physical port 1 with the same decoding.
// [R10] The ports 1-2 remap register resets to 0x21, an identity mapping.
// [R11] Remapping applies only while remap enable is set, otherwise ports keep physical numbers.
// [R12] The hub reports only its count of enabled downstream ports, which the host numbers from 1.
// [R13] Software must program contiguous logical numbers from 1 up to the enabled port count.
// [R14] Reserved bits of the boost and swap registers read as zero and ignore writes.
package hpc_pkg;

    // Register offsets
    localparam logic [7:0] HPC_OFS_BOOST3  = 8'hf6;
    localparam logic [7:0] HPC_OFS_BOOST21 = 8'hf8;
    localparam logic [7:0] HPC_OFS_SWAP    = 8'hfa;
    localparam logic [7:0] HPC_OFS_REMAP12 = 8'hfb;

    // Writable bit masks, reserved bits clear
    localparam logic [7:0] HPC_MASK_BOOST3  = 8'h07;
    localparam logic [7:0] HPC_MASK_BOOST21 = 8'h77;
    localparam logic [7:0] HPC_MASK_SWAP    = 8'h0e;
    localparam logic [7:0] HPC_MASK_REMAP12 = 8'hff;

    // Reset values
    localparam logic [7:0] HPC_RST_BOOST3  = 8'h00;
    localparam logic [7:0] HPC_RST_BOOST21 = 8'h00;
    localparam logic [7:0] HPC_RST_SWAP    = 8'h00;
    localparam logic [7:0] HPC_RST_REMAP12 = 8'h21;

    // Field positions and port count
    localparam int HPC_BOOST_P1_LSB = 0;
    localparam int HPC_BOOST_P2_LSB = 4;
    localparam int HPC_BOOST_P3_LSB = 0;
    localparam int HPC_REMAP_P1_LSB = 0;
    localparam int HPC_REMAP_P2_LSB = 4;
    localparam int HPC_NUM_PORTS    = 3;

    // Boost codes
    localparam logic [2:0] HPC_BST_NOM  = 3'h0;
    localparam logic [2:0] HPC_BST_M5   = 3'h1;
    localparam logic [2:0] HPC_BST_P10  = 3'h2;
    localparam logic [2:0] HPC_BST_P5   = 3'h3;
    localparam logic [2:0] HPC_BST_P20  = 3'h4;
    localparam logic [2:0] HPC_BST_P15  = 3'h5;
    localparam logic [2:0] HPC_BST_P25  = 3'h6;

    // Remap codes
    localparam logic [3:0] HPC_REMAP_OFF  = 4'h0;
    localparam logic [3:0] HPC_REMAP_LAST = 4'h3;

    // Register access request from the configuration serial port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hpc_req_s;

    // One side of a differential data pair
    typedef struct packed {
        logic plus;
        logic minus;
        logic oe;
    } hpc_pair_s;

    typedef logic signed [5:0] hpc_pct_t;

endpackage : hpc_pkg

// ---- logic/hpc_config_regs.sv ----
// Hub port PHY configuration registers with boost, swap and remap outputs
module hpc_config_regs
    import hpc_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Register access port
    input  wire hpc_req_s         req,
    output logic [7:0]            reg_rdata,
    output logic                  reg_ack,
    // Remap enable from the hub configuration
    input  wire logic             remap_enable,
    // Transceiver side data pairs, ports 1 to 3
    input  wire hpc_pair_s [3:1]  xcvr_tx,
    output hpc_pair_s [3:1]       xcvr_rx,
    // Pin side, three signals per pin
    input  wire logic [3:1]       plus_pin_i,
    input  wire logic [3:1]       minus_pin_i,
    output logic [3:1]            plus_pin_o,
    output logic [3:1]            minus_pin_o,
    output logic [3:1]            pin_oe,
    // Transceiver boost outputs
    output logic [2:0]            port1_boost_code,
    output logic [2:0]            port2_boost_code,
    output logic [2:0]            port3_boost_code,
    output hpc_pct_t [3:1]        boost_pct,
    // Polarity swap and port numbering outputs
    output logic [3:1]            swap,
    output logic [1:0]            port1_logical,
    output logic [1:0]            port2_logical,
    output logic [1:0]            port_count
);

    // Boost code to signed percentage
    function automatic hpc_pct_t boost_to_pct(input logic [2:0] code);
        hpc_pct_t pct;
        pct = 6'sd0;
        case (code)
            HPC_BST_M5:  pct = -6'sd5;   // R1
            HPC_BST_P10: pct = 6'sd10;
            HPC_BST_P5:  pct = 6'sd5;
            HPC_BST_P20: pct = 6'sd20;
            HPC_BST_P15: pct = 6'sd15;
            HPC_BST_P25: pct = 6'sd25;   // R4
            default:     pct = 6'sd0;    // R4
        endcase
        return pct;
    endfunction : boost_to_pct

    // Remap nibble to logical number, zero meaning disabled
    function automatic logic [1:0] remap_to_logical(input logic [3:0] code);
        logic [1:0] num;
        num = 2'h0;
        if (code != HPC_REMAP_OFF && code <= HPC_REMAP_LAST) begin
            num = code[1:0];             // R7 R9
        end
        return num;                      // R8
    endfunction : remap_to_logical

    logic [7:0] port3_drive_boost;
    logic [7:0] ports21_drive_boost;
    logic [7:0] line_polarity_swap;
    logic [7:0] port12_number_remap;
    logic [3:1] plus_meta;
    logic [3:1] plus_sync;
    logic [3:1] minus_meta;
    logic [3:1] minus_sync;

    // Address decode
    wire        hit_boost3  = (req.addr == HPC_OFS_BOOST3);
    wire        hit_boost21 = (req.addr == HPC_OFS_BOOST21);
    wire        hit_swap    = (req.addr == HPC_OFS_SWAP);
    wire        hit_remap12 = (req.addr == HPC_OFS_REMAP12);
    logic [7:0] read_mux;
    always_comb begin
        if (hit_boost3) begin
            read_mux = port3_drive_boost;
        end else if (hit_boost21) begin
            read_mux = ports21_drive_boost;
        end else if (hit_swap) begin
            read_mux = line_polarity_swap;
        end else if (hit_remap12) begin
            read_mux = port12_number_remap;
        end else begin
            read_mux = 8'h00;
        end
    end

    // Decoded fields
    wire [2:0] next_p1_code = ports21_drive_boost[HPC_BOOST_P1_LSB +: 3];  // R3
    wire [2:0] next_p2_code = ports21_drive_boost[HPC_BOOST_P2_LSB +: 3];  // R2
    wire [2:0] next_p3_code = port3_drive_boost[HPC_BOOST_P3_LSB +: 3];    // R1
    wire [3:1] next_swap    = line_polarity_swap[3:1];                      // R6
    wire [1:0] map1 = remap_to_logical(port12_number_remap[HPC_REMAP_P1_LSB +: 4]);
    wire [1:0] map2 = remap_to_logical(port12_number_remap[HPC_REMAP_P2_LSB +: 4]);
    wire [1:0] next_log1    = remap_enable ? map1 : 2'h1;                   // R11
    wire [1:0] next_log2    = remap_enable ? map2 : 2'h2;                   // R11
    wire [1:0] next_count   = 2'(HPC_NUM_PORTS) - 2'(next_log1 == 2'h0)
                              - 2'(next_log2 == 2'h0);                      // R12

    // Register writes, reserved bits masked off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port3_drive_boost   <= HPC_RST_BOOST3;
            ports21_drive_boost <= HPC_RST_BOOST21;                         // R3
            line_polarity_swap  <= HPC_RST_SWAP;
            port12_number_remap <= HPC_RST_REMAP12;                         // R10
        end else if (req.wr) begin
            if (hit_boost3) begin
                port3_drive_boost <= req.wdata & HPC_MASK_BOOST3;           // R14
            end
            if (hit_boost21) begin
                ports21_drive_boost <= req.wdata & HPC_MASK_BOOST21;        // R14
            end
            if (hit_swap) begin
                line_polarity_swap <= req.wdata & HPC_MASK_SWAP;            // R6 R14
            end
            if (hit_remap12) begin
                port12_number_remap <= req.wdata & HPC_MASK_REMAP12;
            end
        end
    end

    // Read data and acknowledge, one cycle after the request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_ack   <= 1'b0;
        end else begin
            reg_ack <= req.wr | req.rd;
            if (req.rd) begin
                reg_rdata <= read_mux;                                      // R14
            end
        end
    end

    // Exported settings
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port1_boost_code <= HPC_BST_NOM;
            port2_boost_code <= HPC_BST_NOM;
            port3_boost_code <= HPC_BST_NOM;
            boost_pct        <= '0;
            swap             <= '0;
            port1_logical    <= 2'h1;
            port2_logical    <= 2'h2;
            port_count       <= 2'(HPC_NUM_PORTS);
        end else begin
            port1_boost_code <= next_p1_code;
            port2_boost_code <= next_p2_code;
            port3_boost_code <= next_p3_code;
            boost_pct[1]     <= boost_to_pct(next_p1_code);                 // R3
            boost_pct[2]     <= boost_to_pct(next_p2_code);                 // R2
            boost_pct[3]     <= boost_to_pct(next_p3_code);                 // R1
            swap             <= next_swap;
            port1_logical    <= next_log1;                                  // R9 R11
            port2_logical    <= next_log2;                                  // R7 R11
            port_count       <= next_count;                                 // R12
        end
    end

    // Pin input synchronisers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            plus_meta  <= '0;
            plus_sync  <= '0;
            minus_meta <= '0;
            minus_sync <= '0;
        end else begin
            plus_meta  <= plus_pin_i;
            plus_sync  <= plus_meta;
            minus_meta <= minus_pin_i;
            minus_sync <= minus_meta;
        end
    end

    // Data pair routing through the swap multiplexer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            plus_pin_o  <= '0;
            minus_pin_o <= '0;
            pin_oe      <= '0;
            xcvr_rx     <= '0;
        end else begin
            for (int p = 1; p <= HPC_NUM_PORTS; p++) begin
                pin_oe[p]        <= xcvr_tx[p].oe;
                xcvr_rx[p].oe    <= 1'b0;
                if (next_swap[p]) begin
                    plus_pin_o[p]     <= xcvr_tx[p].minus;                  // R5
                    minus_pin_o[p]    <= xcvr_tx[p].plus;
                    xcvr_rx[p].plus   <= minus_sync[p];
                    xcvr_rx[p].minus  <= plus_sync[p];
                end else begin
                    plus_pin_o[p]     <= xcvr_tx[p].plus;                   // R5
                    minus_pin_o[p]    <= xcvr_tx[p].minus;
                    xcvr_rx[p].plus   <= plus_sync[p];
                    xcvr_rx[p].minus  <= minus_sync[p];
                end
            end
        end
    end

    // Checks
    AST_P3_DECODE: assert property (@(posedge clk) disable iff (rst) // R1
        port3_drive_boost[2:0] == HPC_BST_P20 |=> boost_pct[3] == 6'sd20)
        else $error("port 3 boost code 100 not decoded as +20");
    AST_P2_FIELD: assert property (@(posedge clk) disable iff (rst) // R2
        req.wr && hit_boost21 |=> ##1 port2_boost_code == $past(req.wdata[6:4], 2))
        else $error("port 2 boost code not taken from bits 6:4");
    AST_P1_RESET: assert property (@(posedge clk) disable iff (rst) // R3
        $fell(rst) |-> ports21_drive_boost == 8'h00 && boost_pct[1] == 6'sd0)
        else $error("shared boost register not reset to nominal");
    AST_P25_CODE: assert property (@(posedge clk) disable iff (rst) // R4
        port3_drive_boost[2:0] == 3'h6 |=> boost_pct[3] == 6'sd25)
        else $error("boost code 110 not decoded as +25");
    AST_P7_NOMINAL: assert property (@(posedge clk) disable iff (rst) // R4
        port3_drive_boost[2:0] == 3'h7 |=> boost_pct[3] == 6'sd0)
        else $error("boost code 111 not decoded as nominal");
    // The release edge still runs the reset branch, so it is left out
    AST_SWAP_ROUTE: assert property (@(posedge clk) disable iff (rst) // R5
        !rst && !next_swap[1] |=> plus_pin_o[1] == $past(xcvr_tx[1].plus)
        && minus_pin_o[1] == $past(xcvr_tx[1].minus))
        else $error("port 1 pair not routed straight with swap clear");
    AST_SWAP_RSVD: assert property (@(posedge clk) disable iff (rst) // R6
        req.rd && hit_swap |=> reg_rdata[0] == 1'b0 && reg_rdata[7:4] == 4'h0)
        else $error("reserved swap bits read nonzero");
    AST_REMAP_HIGH: assert property (@(posedge clk) disable iff (rst) // R8
        remap_enable && port12_number_remap[7:4] >= 4'h4 |=> port2_logical == 2'h0)
        else $error("reserved remap code did not disable port 2");
    AST_REMAP_LOW: assert property (@(posedge clk) disable iff (rst) // R9
        remap_enable && port12_number_remap[3:0] == 4'h3 |=> port1_logical == 2'h3)
        else $error("port 1 remap code 0011 not applied");
    AST_REMAP_UP: assert property (@(posedge clk) disable iff (rst) // R7
        remap_enable && port12_number_remap[7:4] == 4'h1 |=> port2_logical == 2'h1)
        else $error("port 2 remap code 0001 not applied");
    AST_REMAP_RST: assert property (@(posedge clk) disable iff (rst) // R10
        $fell(rst) |-> port12_number_remap == 8'h21)
        else $error("remap register not reset to 0x21");
    AST_REMAP_OFF: assert property (@(posedge clk) disable iff (rst) // R11
        !remap_enable |=> port1_logical == 2'h1 && port2_logical == 2'h2)
        else $error("physical numbering lost with remap disabled");
    AST_COUNT: assert property (@(posedge clk) disable iff (rst) // R12
        remap_enable && map1 == 2'h0 && map2 == 2'h0 |=> port_count == 2'h1)
        else $error("port count ignores disabled ports");
    AST_RSVD_B3: assert property (@(posedge clk) disable iff (rst) // R14
        req.rd && hit_boost3 |=> reg_rdata[7:3] == 5'h00)
        else $error("reserved port 3 boost bits read nonzero");

endmodule : hpc_config_regs
